// ### verilog/spio_map.vh
// register map, field layout and reset values of the shared parallel i/o ports
//
// Functional notes
// - driving enabled peripheral disables port driver
// - idle enabled peripheral leaves pin to port
// - direction bit one means input
// - reset makes every implemented pin input
// - latch reads latch, writes update latch
// - pin register reads pins, writes latch
// - unimplemented bits disabled and read zero
// - input-only shared pin acts as dedicated
// - peripheral wins data and enable multiplexers
// - analog-configured pins read as zero
// - registers at even word addresses, except port b latch at odd 02cb
// - direction resets to implemented-bit mask
// - pin-read and latch reset to zero
`ifndef SPIO_MAP_VH
`define SPIO_MAP_VH

// ------------------------------------------------------------
// widths
// ------------------------------------------------------------
`define SPIO_ADDR_W 16
`define SPIO_DATA_W 16
`define SPIO_PORT_W 16

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define SPIO_OFF_DIR_A 16'h02c0
`define SPIO_OFF_PINS_A 16'h02c2
`define SPIO_OFF_LATCH_A 16'h02c4
`define SPIO_OFF_DIR_B 16'h02c6
`define SPIO_OFF_PINS_B 16'h02c8
`define SPIO_OFF_LATCH_B 16'h02cb
`define SPIO_OFF_ANALOG_A 16'h02f0
`define SPIO_OFF_ANALOG_B 16'h02f2

// ------------------------------------------------------------
// reset values and implemented-bit masks
// ------------------------------------------------------------
`define SPIO_IMPL_A 16'hc600
`define SPIO_IMPL_B 16'hffff
`define SPIO_RST_DIR_A 16'hc600
`define SPIO_RST_DIR_B 16'hffff
`define SPIO_RST_PINS 16'h0000
`define SPIO_RST_LATCH 16'h0000
`define SPIO_RST_ANALOG 16'h0000
`define SPIO_RD_IDLE 16'h0000

`endif

// ### verilog/spio_pad_mux.v
// per-pin output data and output-enable multiplexers between port and peripheral
`timescale 1ns/1ns
module spio_pad_mux #(
  parameter WIDTH = 16
) (
  input wire [WIDTH-1:0] dir,
  input wire [WIDTH-1:0] latch,
  input wire [WIDTH-1:0] impl_mask,
  input wire [WIDTH-1:0] periph_mask,
  input wire [WIDTH-1:0] periph_en,
  input wire [WIDTH-1:0] periph_oe,
  input wire [WIDTH-1:0] periph_out,
  output wire [WIDTH-1:0] pad_out,
  output wire [WIDTH-1:0] pad_oe
);

  genvar i;

  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
      wire periph_owns;
      wire port_oe;
      // input-only sharers have no mask bit, so they never take the pad
      assign periph_owns = periph_mask[i] & periph_en[i] & periph_oe[i];
      assign port_oe = impl_mask[i] & ~dir[i];
      assign pad_out[i] = periph_owns ? periph_out[i] : latch[i];
      assign pad_oe[i] = periph_owns ? impl_mask[i] : port_oe;
    end
  endgenerate

endmodule

// ### verilog/spio_top.v
// shared parallel i/o ports a and b: register file, pin synchroniser and pad drive
`timescale 1ns/1ns
`include "spio_map.vh"
module spio_top #(
  parameter NPORTS = 2,
  parameter [NPORTS*16-1:0] IMPL_MASK = {`SPIO_IMPL_B, `SPIO_IMPL_A},
  parameter [NPORTS*16-1:0] DIR_RESET = {`SPIO_RST_DIR_B, `SPIO_RST_DIR_A},
  parameter [NPORTS*16-1:0] PERIPH_MASK = {16'hffff, 16'hffff}
) (
  input wire CLK_SYS,
  input wire RST,
  input wire CE,
  input wire [`SPIO_ADDR_W-1:0] ADDR,
  input wire [`SPIO_DATA_W-1:0] WR_DATA,
  input wire WR_EN,
  input wire RD_EN,
  output wire [`SPIO_DATA_W-1:0] RD_DATA,
  input wire [NPORTS*16-1:0] PAD_IN,
  output wire [NPORTS*16-1:0] PAD_OUT,
  output wire [NPORTS*16-1:0] PAD_OE,
  input wire [NPORTS*16-1:0] PERIPH_EN,
  input wire [NPORTS*16-1:0] PERIPH_OE,
  input wire [NPORTS*16-1:0] PERIPH_OUT
);

  // ------------------------------------------------------------
  // address decode helpers
  // ------------------------------------------------------------
  function hit;
    input [`SPIO_ADDR_W-1:0] a;
    input [`SPIO_ADDR_W-1:0] off;
    input stb;
    begin
      hit = stb & (a == off);
    end
  endfunction

  function [`SPIO_ADDR_W-1:0] off_of;
    input integer port;
    input integer kind;
    begin
      off_of = 16'h0000;
      case (kind)
        0: off_of = (port == 0) ? `SPIO_OFF_DIR_A : `SPIO_OFF_DIR_B;
        1: off_of = (port == 0) ? `SPIO_OFF_PINS_A : `SPIO_OFF_PINS_B;
        2: off_of = (port == 0) ? `SPIO_OFF_LATCH_A : `SPIO_OFF_LATCH_B;
        3: off_of = (port == 0) ? `SPIO_OFF_ANALOG_A : `SPIO_OFF_ANALOG_B;
        default: off_of = 16'h0000;
      endcase
    end
  endfunction

  localparam KIND_DIR = 0;
  localparam KIND_PINS = 1;
  localparam KIND_LATCH = 2;
  localparam KIND_ANALOG = 3;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  reg [NPORTS*16-1:0] dir_ff;
  reg [NPORTS*16-1:0] latch_ff;
  reg [NPORTS*16-1:0] analog_ff;
  reg [NPORTS*16-1:0] sync1_ff;
  reg [NPORTS*16-1:0] sync2_ff;
  reg [NPORTS*16-1:0] pad_out_ff;
  reg [NPORTS*16-1:0] pad_oe_ff;
  reg [`SPIO_DATA_W-1:0] rd_data_ff;

  wire [NPORTS*16-1:0] nxt_dir;
  wire [NPORTS*16-1:0] nxt_latch;
  wire [NPORTS*16-1:0] nxt_analog;
  wire [NPORTS*16-1:0] nxt_pad_out;
  wire [NPORTS*16-1:0] nxt_pad_oe;
  wire [NPORTS*16-1:0] pin_view;
  wire [NPORTS*16-1:0] rd_word;
  wire [NPORTS-1:0] rd_hit;
  reg [`SPIO_DATA_W-1:0] nxt_rd_data;

  assign RD_DATA = rd_data_ff;
  assign PAD_OUT = pad_out_ff;
  assign PAD_OE = pad_oe_ff;

  // ------------------------------------------------------------
  // per-port register behaviour
  // ------------------------------------------------------------
  genvar p;

  generate
    for (p = 0; p < NPORTS; p = p + 1) begin : g_port
      wire [15:0] impl;
      wire wr_dir;
      wire wr_pins;
      wire wr_latch;
      wire wr_analog;
      wire hit_dir;
      wire hit_pins;
      wire hit_latch;
      wire hit_analog;

      assign impl = IMPL_MASK[p*16 +: 16];

      assign wr_dir = hit(ADDR, off_of(p, KIND_DIR), WR_EN);
      assign wr_pins = hit(ADDR, off_of(p, KIND_PINS), WR_EN);
      assign wr_latch = hit(ADDR, off_of(p, KIND_LATCH), WR_EN);
      assign wr_analog = hit(ADDR, off_of(p, KIND_ANALOG), WR_EN);
      assign hit_dir = hit(ADDR, off_of(p, KIND_DIR), RD_EN);
      assign hit_pins = hit(ADDR, off_of(p, KIND_PINS), RD_EN);
      assign hit_latch = hit(ADDR, off_of(p, KIND_LATCH), RD_EN);
      assign hit_analog = hit(ADDR, off_of(p, KIND_ANALOG), RD_EN);

      // unimplemented bits cannot be set, so they stay zero for good
      assign nxt_dir[p*16 +: 16] = wr_dir ? (WR_DATA & impl) : dir_ff[p*16 +: 16];
      // a write to the pin register lands in the latch
      assign nxt_latch[p*16 +: 16] = (wr_latch | wr_pins) ? (WR_DATA & impl) :
                                     latch_ff[p*16 +: 16];
      assign nxt_analog[p*16 +: 16] = wr_analog ? (WR_DATA & impl) : analog_ff[p*16 +: 16];

      // analog pins read low whatever the pad level
      assign pin_view[p*16 +: 16] = sync2_ff[p*16 +: 16] & impl & ~analog_ff[p*16 +: 16];

      assign rd_hit[p] = hit_dir | hit_pins | hit_latch | hit_analog;
      assign rd_word[p*16 +: 16] = hit_dir ? dir_ff[p*16 +: 16] :
                                   hit_pins ? pin_view[p*16 +: 16] :
                                   hit_latch ? latch_ff[p*16 +: 16] :
                                   hit_analog ? analog_ff[p*16 +: 16] :
                                   `SPIO_RD_IDLE;

      spio_pad_mux #(
        .WIDTH(16)
      ) u_pad_mux (
        .dir(dir_ff[p*16 +: 16]),
        .latch(latch_ff[p*16 +: 16]),
        .impl_mask(impl),
        .periph_mask(PERIPH_MASK[p*16 +: 16]),
        .periph_en(PERIPH_EN[p*16 +: 16]),
        .periph_oe(PERIPH_OE[p*16 +: 16]),
        .periph_out(PERIPH_OUT[p*16 +: 16]),
        .pad_out(nxt_pad_out[p*16 +: 16]),
        .pad_oe(nxt_pad_oe[p*16 +: 16])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // read data mux
  // ------------------------------------------------------------
  integer k;

  always @* begin
    nxt_rd_data = `SPIO_RD_IDLE;
    // unmapped addresses and idle cycles answer zero
    for (k = 0; k < NPORTS; k = k + 1) begin
      if (rd_hit[k]) begin
        nxt_rd_data = rd_word[k*16 +: 16];
      end
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      dir_ff <= DIR_RESET;
      latch_ff <= {NPORTS{`SPIO_RST_LATCH}};
      analog_ff <= {NPORTS{`SPIO_RST_ANALOG}};
      sync1_ff <= {NPORTS{`SPIO_RST_PINS}};
      sync2_ff <= {NPORTS{`SPIO_RST_PINS}};
      pad_out_ff <= {NPORTS{16'h0000}};
      pad_oe_ff <= {NPORTS{16'h0000}};
      rd_data_ff <= `SPIO_RD_IDLE;
    end else if (CE) begin
      dir_ff <= nxt_dir;
      latch_ff <= nxt_latch;
      analog_ff <= nxt_analog;
      // pads are asynchronous to the core clock
      sync1_ff <= PAD_IN;
      sync2_ff <= sync1_ff;
      // one flop of latency on the pads keeps outputs glitch free
      pad_out_ff <= nxt_pad_out;
      pad_oe_ff <= nxt_pad_oe;
      rd_data_ff <= nxt_rd_data;
    end
  end

endmodule

// ### sim/spio_chk_sva.sv
// checker: port-level properties of the shared parallel i/o ports
`timescale 1ns/1ns
module spio_chk #(
  parameter logic [31:0] PERIPH_MASK = 32'hffff_ffff
) (
  input wire CLK_SYS,
  input wire RST,
  input wire CE,
  input wire [15:0] ADDR,
  input wire [15:0] WR_DATA,
  input wire WR_EN,
  input wire RD_EN,
  input wire [15:0] RD_DATA,
  input wire [31:0] PAD_IN,
  input wire [31:0] PAD_OUT,
  input wire [31:0] PAD_OE,
  input wire [31:0] PERIPH_EN,
  input wire [31:0] PERIPH_OE,
  input wire [31:0] PERIPH_OUT
);
  localparam logic [31:0] IMPL = 32'hffff_c600;
  // input-only sharers never own their pad
  wire [31:0] own = PERIPH_EN & PERIPH_OE & PERIPH_MASK;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  sequence s_steady; $stable(PAD_IN[31:16])[*3]; endsequence
  sequence s_lat_wr; CE && WR_EN && ADDR == 16'h02c4 ##1 CE; endsequence
  property p_own_out; CE |=> ((PAD_OUT ^ $past(PERIPH_OUT)) & $past(own)) == 32'h0000_0000; endproperty
  a_own_out: assert property (p_own_out) else $error("pad data not taken from peripheral");
  property p_own_oe; CE |=> (PAD_OE & $past(own)) == ($past(own) & IMPL); endproperty
  a_own_oe: assert property (p_own_oe) else $error("owned pad enable wrong");
  property p_unimpl_oe; (PAD_OE & ~IMPL) == 32'h0000_0000; endproperty
  a_unimpl_oe: assert property (p_unimpl_oe) else $error("unimplemented pad driven");
  property p_rd_idle; CE && !RD_EN |=> RD_DATA == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_unimpl_rd;
    CE && RD_EN && (ADDR == 16'h02c0 || ADDR == 16'h02c2 || ADDR == 16'h02c4) |=> (RD_DATA & 16'h39ff) == 16'h0000;
  endproperty
  a_unimpl_rd: assert property (p_unimpl_rd) else $error("unimplemented bit reads one");
  property p_unmapped; CE && RD_EN && ADDR == 16'h02ca |=> RD_DATA == 16'h0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("hole in map reads nonzero");
  property p_pin_rd; s_steady ##0 (CE && RD_EN && ADDR == 16'h02c8) |=> RD_DATA == $past(PAD_IN[31:16]); endproperty
  a_pin_rd: assert property (p_pin_rd) else $error("pin read differs from pads");
  property p_rst_in; $fell(RST) && own == 32'h0000_0000 |-> PAD_OE == 32'h0000_0000; endproperty
  a_rst_in: assert property (p_rst_in) else $error("pad driven after reset");
  property p_lat_out;
    s_lat_wr |=> (PAD_OUT[15:0] & ~$past(own[15:0])) == ($past(WR_DATA, 2) & 16'hc600 & ~$past(own[15:0]));
  endproperty
  a_lat_out: assert property (p_lat_out) else $error("latch write not on pads");
endmodule
bind spio_top spio_chk #(.PERIPH_MASK(PERIPH_MASK)) u_chk (.CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .ADDR(ADDR),
  .WR_DATA(WR_DATA),
  .WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA), .PAD_IN(PAD_IN), .PAD_OUT(PAD_OUT), .PAD_OE(PAD_OE),
  .PERIPH_EN(PERIPH_EN), .PERIPH_OE(PERIPH_OE), .PERIPH_OUT(PERIPH_OUT));

// ### sim/spio_pins_model.sv
// far-side pads: driven pads loop back, undriven pads show the board level
`timescale 1ns/1ns
module spio_pins_model (
  input wire [31:0] pad_out,
  input wire [31:0] pad_oe,
  input wire [31:0] ext,
  output wire [31:0] pad_in
);
  // undriven pad shows the board level, never the last driven value
  assign pad_in = (pad_out & pad_oe) | (ext & ~pad_oe);
endmodule

// ### sim/spio_top_tb.sv
// testbench: register and pad scenarios for the shared parallel i/o ports
`timescale 1ns/1ns
module spio_top_tb;
  reg CLK_SYS = 0, RST = 1, CE = 1, WR_EN = 0, RD_EN = 0;
  reg [15:0] ADDR = 0, WR_DATA = 0;
  reg [31:0] PERIPH_EN = 0, PERIPH_OE = 0, PERIPH_OUT = 0, ext = 0;
  wire [15:0] RD_DATA;
  wire [31:0] PAD_IN, PAD_OUT, PAD_OE;
  int n_mismatch = 0, n_compared = 0;
  logic [15:0] offs [6] = '{16'h02c0, 16'h02c2, 16'h02c4, 16'h02c6, 16'h02c8, 16'h02cb};
  logic [15:0] rstv [6] = '{16'hc600, 16'h0000, 16'h0000, 16'hffff, 16'h0000, 16'h0000};
  // pin 17 stands for an input-only sharer, so its peripheral never takes the pad
  spio_top #(.PERIPH_MASK(32'hfffd_ffff)) dut (.CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .ADDR(ADDR),
    .WR_DATA(WR_DATA), .WR_EN(WR_EN),
    .RD_EN(RD_EN), .RD_DATA(RD_DATA), .PAD_IN(PAD_IN), .PAD_OUT(PAD_OUT), .PAD_OE(PAD_OE),
    .PERIPH_EN(PERIPH_EN), .PERIPH_OE(PERIPH_OE), .PERIPH_OUT(PERIPH_OUT));
  spio_pins_model pins (.pad_out(PAD_OUT), .pad_oe(PAD_OE), .ext(ext), .pad_in(PAD_IN));
  initial forever #5 CLK_SYS = ~CLK_SYS;
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge CLK_SYS);
    WR_EN <= 1;
    ADDR <= a;
    WR_DATA <= d;
    @(posedge CLK_SYS);
    WR_EN <= 0;
  endtask
  task rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge CLK_SYS);
    RD_EN <= 1;
    ADDR <= a;
    @(posedge CLK_SYS);
    RD_EN <= 0;
    #1 chk($sformatf("register %h", a), {16'h0000, exp}, {16'h0000, RD_DATA});
  endtask
  task conclude;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge CLK_SYS);
    RST <= 0;
    for (int i = 0; i < 6; i++) rd(offs[i], rstv[i]);
    chk("pad enable", 32'h0000_0000, PAD_OE);
    $display("test reset done");
    wr(16'h02c4, 16'hffff);
    rd(16'h02c4, 16'hc600);
    wr(16'h02c2, 16'h5555);
    rd(16'h02c4, 16'h4400);
    wr(16'h02c0, 16'h0000);
    wr(16'h02c6, 16'h0000);
    wr(16'h02cb, 16'h1234);
    repeat (4) @(posedge CLK_SYS);
    #1 chk("pad enable", 32'hffff_c600, PAD_OE);
    chk("pad data", 32'h1234_4400, PAD_OUT);
    rd(16'h02c2, 16'h4400);
    rd(16'h02c8, 16'h1234);
    $display("test latch done");
    @(posedge CLK_SYS);
    PERIPH_EN <= 32'h0003_0000;
    PERIPH_OUT <= 32'h0003_0000;
    repeat (2) @(posedge CLK_SYS);
    #1 chk("idle peripheral pad", 32'h0000_0000, {31'h0, PAD_OUT[16]});
    chk("idle peripheral enable", 32'h0000_0001, {31'h0, PAD_OE[16]});
    @(posedge CLK_SYS);
    PERIPH_OE <= 32'h0003_0000;
    repeat (2) @(posedge CLK_SYS);
    #1 chk("owned pad", 32'h0000_0001, {31'h0, PAD_OUT[16]});
    chk("input-only sharer pad", 32'h0000_0000, {31'h0, PAD_OUT[17]});
    repeat (2) @(posedge CLK_SYS);
    rd(16'h02c8, 16'h1235);
    $display("test peripheral done");
    wr(16'h02ca, 16'hffff);
    rd(16'h02ca, 16'h0000);
    rd(16'h02cb, 16'h1234);
    $display("test map done");
    @(posedge CLK_SYS);
    CE <= 0;
    wr(16'h02c4, 16'h0000);
    @(posedge CLK_SYS);
    CE <= 1;
    rd(16'h02c4, 16'h4400);
    $display("test clock enable done");
    @(posedge CLK_SYS);
    ext <= 32'h0000_c600;
    wr(16'h02c0, 16'hffff);
    wr(16'h02f0, 16'h8000);
    repeat (4) @(posedge CLK_SYS);
    rd(16'h02c2, 16'h4600);
    $display("test analog done");
    @(posedge CLK_SYS);
    ext <= 32'h0000_0000;
    PERIPH_EN <= 32'h0000_0000;
    PERIPH_OE <= 32'h0000_0000;
    RST <= 1;
    repeat (5) @(posedge CLK_SYS);
    RST <= 0;
    for (int i = 0; i < 6; i++) rd(offs[i], rstv[i]);
    chk("pad enable after reset", 32'h0000_0000, PAD_OE);
    $display("test second reset done");
    conclude();
  end
endmodule
